// file: src/sync_check_defines.svh
// Register indices, field positions, codes and timing figures
`ifndef SYNC_CHECK_DEFINES_SVH
`define SYNC_CHECK_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_WD_DIV 12'h400
`define IDX_WD_TIME 12'h420
`define IDX_SM_CTRL 12'h804
`define IDX_DC_ACT 12'h981
`define IDX_ESM_CTRL 12'h010
`define IDX_CYCLE 12'h011
`define IDX_ESM_STAT 12'h012
`define IDX_IRQ_STAT 12'h013
`define IDX_IRQ_CLR 12'h014
`define IDX_IRQ_EN 12'h015

// Field positions
`define SM_WD_TRIG_BIT 6
`define CTRL_REQ_SAFEOP_BIT 4
`define CTRL_ALARM_CLR_BIT 5
`define CTRL_BACK_PREOP_BIT 6

// Field codes
`define SM0_MBX_CODE 4'h6
`define DC_ACT_OFF 3'h0
`define DC_ACT_SYNC0 3'h3

// Status codes
`define AL_CODE_NONE 16'h0000
`define AL_CODE_MBX 16'h0016
`define AL_CODE_WD 16'h001f
`define AL_CODE_DC 16'h0030

// Reset values
`define RST_WD_DIV 16'h0000
`define RST_WD_TIME 16'h0000
`define RST_SM_CTRL 8'h00
`define RST_DC_ACT 8'h00
`define RST_CYCLE 32'h0000_0000

// Timing
`define WD_TICK_NS 40
`define FREERUN_MIN_WD_NS 2000000
`define CLK_PERIOD_NS 4
`define BLINK_HALF_MS 200

`endif

// file: src/sync_check_pkg.sv
// Types shared by the configuration checker
`default_nettype none
package sync_check_pkg;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_PREOP = 2'b01,
    ST_CHECK = 2'b10,
    ST_SAFEOP = 2'b11
  } esm_state_t;

  typedef enum logic [1:0] {
    SYNC_FREE_RUN = 2'b00,
    SYNC_SM2 = 2'b01,
    SYNC_DC = 2'b10
  } sync_mode_t;
endpackage
`default_nettype wire

// file: src/blink_divider.sv
// Error indicator blink generator
`default_nettype none
module blink_divider #(
  parameter int HALF_CYCLES = 50000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  output logic blink
);
  localparam int CW = $clog2(HALF_CYCLES + 1);

  generate
    if (HALF_CYCLES < 1) begin : g_bad
      $error("HALF_CYCLES must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_q;
  logic blink_q;
  logic en_q;

  // First enabled cycle restarts the half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!enable || !en_q || cnt_q == CW'(HALF_CYCLES - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Starts lit as soon as enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_q <= 1'b0;
    end else if (!enable) begin
      blink_q <= 1'b0;
    end else if (!en_q) begin
      blink_q <= 1'b1;
    end else if (cnt_q == CW'(HALF_CYCLES - 1)) begin
      blink_q <= ~blink_q;
    end
  end

  assign blink = blink_q;
endmodule // blink_divider
`default_nettype wire

// file: src/sync_config_checker.sv
// Watchdog and clock-sync setup checker with APB registers
`include "sync_check_defines.svh"
`default_nettype none

module sync_config_checker
  import sync_check_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES =
    `BLINK_HALF_MS * 1000000 / `CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] esm_state,
  output logic watchdog_setup_alarm,
  output logic clock_sync_setting_alarm,
  output logic mailbox_setup_alarm,
  output logic err_led,
  output logic irq
);
  generate
    if (BLINK_HALF_CYCLES < 1) begin : g_bad
      $error("BLINK_HALF_CYCLES must be at least one");
    end
  endgenerate

  function automatic logic hit(input logic [13:0] a, input logic [11:0] idx);
    hit = (a[13:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic mapped(input logic [13:0] a);
    mapped = hit(a, `IDX_WD_DIV) || hit(a, `IDX_WD_TIME) ||
      hit(a, `IDX_SM_CTRL) || hit(a, `IDX_DC_ACT) ||
      hit(a, `IDX_ESM_CTRL) || hit(a, `IDX_CYCLE) ||
      hit(a, `IDX_ESM_STAT) || hit(a, `IDX_IRQ_STAT) ||
      hit(a, `IDX_IRQ_CLR) || hit(a, `IDX_IRQ_EN);
  endfunction

  logic [15:0] wd_div_q;
  logic [15:0] wd_time_q;
  logic [7:0] sm_ctrl_q;
  logic [7:0] dc_act_q;
  logic [31:0] cycle_q;
  sync_mode_t mode_q;
  esm_state_t esm_q;
  logic [15:0] al_code_q;
  logic wd_alarm_q;
  logic dc_alarm_q;
  logic mbx_alarm_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic [31:0] prdata_q;

  logic wr;
  logic req_safeop;
  logic alarm_clr;
  logic back_preop;
  logic [22:0] wd_tick_ns;
  logic [47:0] wd_timeout_ns;
  logic [47:0] wd_floor_ns;
  logic wd_trig;
  logic wd_err;
  logic dc_err;
  logic mbx_err;
  logic any_err;
  logic in_check;
  logic [3:0] irq_evt;
  logic [3:0] irq_clr;

  // APB: zero-wait access, read data captured in setup
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  assign req_safeop = wr && hit(paddr, `IDX_ESM_CTRL) &&
    pwdata[`CTRL_REQ_SAFEOP_BIT];
  assign alarm_clr = wr && hit(paddr, `IDX_ESM_CTRL) &&
    pwdata[`CTRL_ALARM_CLR_BIT];
  assign back_preop = wr && hit(paddr, `IDX_ESM_CTRL) &&
    pwdata[`CTRL_BACK_PREOP_BIT];
  assign irq_clr = (wr && hit(paddr, `IDX_IRQ_CLR)) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_div_q <= `RST_WD_DIV;
      wd_time_q <= `RST_WD_TIME;
      sm_ctrl_q <= `RST_SM_CTRL;
      dc_act_q <= `RST_DC_ACT;
      cycle_q <= `RST_CYCLE;
      mode_q <= SYNC_FREE_RUN;
      irq_en_q <= 4'h0;
    end else if (wr) begin
      if (hit(paddr, `IDX_WD_DIV)) begin
        wd_div_q <= pwdata[15:0];
      end
      if (hit(paddr, `IDX_WD_TIME)) begin
        wd_time_q <= pwdata[15:0];
      end
      if (hit(paddr, `IDX_SM_CTRL)) begin
        sm_ctrl_q <= pwdata[7:0];
      end
      if (hit(paddr, `IDX_DC_ACT)) begin
        dc_act_q <= pwdata[7:0];
      end
      if (hit(paddr, `IDX_CYCLE)) begin
        cycle_q <= pwdata;
      end
      if (hit(paddr, `IDX_ESM_CTRL)) begin
        mode_q <= sync_mode_t'(pwdata[1:0]);
      end
      if (hit(paddr, `IDX_IRQ_EN)) begin
        irq_en_q <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      if (hit(paddr, `IDX_WD_DIV)) prdata_q <= {16'h0000, wd_div_q};
      if (hit(paddr, `IDX_WD_TIME)) prdata_q <= {16'h0000, wd_time_q};
      if (hit(paddr, `IDX_SM_CTRL)) prdata_q <= {24'h00_0000, sm_ctrl_q};
      if (hit(paddr, `IDX_DC_ACT)) prdata_q <= {24'h00_0000, dc_act_q};
      if (hit(paddr, `IDX_CYCLE)) prdata_q <= cycle_q;
      if (hit(paddr, `IDX_ESM_CTRL)) prdata_q <= {30'h0, mode_q};
      if (hit(paddr, `IDX_ESM_STAT)) begin
        prdata_q <= {al_code_q, 9'h000, mbx_alarm_q, dc_alarm_q,
          wd_alarm_q, 2'b00, esm_q};
      end
      if (hit(paddr, `IDX_IRQ_STAT)) prdata_q <= {28'h0, irq_stat_q};
      if (hit(paddr, `IDX_IRQ_EN)) prdata_q <= {28'h0, irq_en_q};
    end
  end
  assign prdata = prdata_q;

  // Watchdog timeout in ns: (divider + 2) * 40 ns per tick
  assign wd_tick_ns = 23'(({7'h00, wd_div_q} + 23'h00_0002) *
    23'(`WD_TICK_NS));
  assign wd_timeout_ns = 48'(wd_tick_ns) * 48'(wd_time_q);

  // Floor is twice the cycle, or fixed in free run
  assign wd_floor_ns = (mode_q == SYNC_FREE_RUN) ?
    48'(`FREERUN_MIN_WD_NS) :
    {15'h0000, cycle_q, 1'b0};
  assign wd_trig = sm_ctrl_q[`SM_WD_TRIG_BIT];
  // Same checks whatever the sync mode
  assign wd_err = wd_trig && (wd_timeout_ns < wd_floor_ns);
  assign dc_err = (dc_act_q[2:0] != `DC_ACT_OFF) &&
    (dc_act_q[2:0] != `DC_ACT_SYNC0);
  assign mbx_err = sm_ctrl_q[3:0] != `SM0_MBX_CODE;
  assign any_err = wd_err || dc_err || mbx_err;
  assign in_check = esm_q == ST_CHECK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esm_q <= ST_PREOP;
    end else begin
      case (esm_q)
        ST_PREOP: if (req_safeop) esm_q <= ST_CHECK;
        ST_CHECK: esm_q <= any_err ? ST_PREOP : ST_SAFEOP;
        ST_SAFEOP: if (back_preop) esm_q <= ST_PREOP;
        ST_INIT: if (req_safeop) esm_q <= ST_PREOP;
        default: esm_q <= ST_PREOP;
      endcase
    end
  end

  // Alarm flags: a new detection wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_alarm_q <= 1'b0;
      dc_alarm_q <= 1'b0;
      mbx_alarm_q <= 1'b0;
    end else begin
      wd_alarm_q <= (in_check && wd_err) || (wd_alarm_q && !alarm_clr);
      dc_alarm_q <= (in_check && dc_err) || (dc_alarm_q && !alarm_clr);
      mbx_alarm_q <= (in_check && mbx_err) ||
        (mbx_alarm_q && !alarm_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_code_q <= `AL_CODE_NONE;
    end else if (in_check && wd_err) begin
      al_code_q <= `AL_CODE_WD;
    end else if (in_check && dc_err) begin
      al_code_q <= `AL_CODE_DC;
    end else if (in_check && mbx_err) begin
      al_code_q <= `AL_CODE_MBX;
    end else if (alarm_clr) begin
      al_code_q <= `AL_CODE_NONE;
    end
  end

  // Interrupt events: wd, dc, mailbox, SafeOP reached
  assign irq_evt = {in_check && !any_err, in_check && mbx_err,
    in_check && dc_err, in_check && wd_err};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= irq_evt | (irq_stat_q & ~irq_clr);
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  blink_divider #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .enable(wd_alarm_q || dc_alarm_q || mbx_alarm_q),
    .blink(err_led)
  );

  assign esm_state = esm_q;
  assign watchdog_setup_alarm = wd_alarm_q;
  assign clock_sync_setting_alarm = dc_alarm_q;
  assign mailbox_setup_alarm = mbx_alarm_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Transition, status and indicator checks
  wd_trigger_a: assert property (
    in_check && !sm_ctrl_q[`SM_WD_TRIG_BIT] && !wd_alarm_q
    |=> !wd_alarm_q)
    else $error("watchdog alarm raised without trigger");
  wd_cycle_a: assert property (
    in_check && mode_q != SYNC_FREE_RUN && wd_trig &&
    wd_timeout_ns < {15'h0000, cycle_q, 1'b0}
    |=> wd_alarm_q && al_code_q == `AL_CODE_WD)
    else $error("short watchdog against cycle not flagged");
  wd_floor_a: assert property (
    in_check && mode_q == SYNC_FREE_RUN && wd_trig &&
    wd_timeout_ns < 48'(`FREERUN_MIN_WD_NS)
    |=> wd_alarm_q ##0 esm_q == ST_PREOP)
    else $error("short free-run watchdog not flagged");
  dc_code_a: assert property (
    in_check && dc_act_q[2:0] != 3'h0 && dc_act_q[2:0] != 3'h3
    |=> dc_alarm_q)
    else $error("bad activation code not flagged");
  check_window_a: assert property (
    $rose(wd_alarm_q) || $rose(dc_alarm_q) |-> $past(esm_q) == ST_CHECK)
    else $error("alarm raised outside the transition");
  fallback_a: assert property (
    in_check && (wd_err || dc_err)
    |=> esm_q == ST_PREOP ##1 esm_q != ST_SAFEOP)
    else $error("transition completed despite error");
  dc_status_a: assert property (
    in_check && !wd_err && dc_err |=> al_code_q == `AL_CODE_DC)
    else $error("wrong status code for clock sync error");
  priority_a: assert property (
    in_check && wd_err && dc_err |=> al_code_q == `AL_CODE_WD)
    else $error("watchdog code did not take priority");
  alarm_clr_a: assert property (
    alarm_clr && !in_check |=> !wd_alarm_q && !dc_alarm_q &&
    !mbx_alarm_q ##1 !err_led)
    else $error("alarm clear did not take effect");
  mbx_code_a: assert property (
    in_check && sm_ctrl_q[3:0] != 4'h6 |=> mbx_alarm_q)
    else $error("bad mailbox code not flagged");
  safeop_ok_a: assert property (
    in_check && !any_err |=> esm_q == ST_SAFEOP)
    else $error("clean transition did not reach SafeOP");
  wd_status_a: assert property (
    in_check && wd_err |=> al_code_q == `AL_CODE_WD && esm_q == ST_PREOP)
    else $error("wrong status code for watchdog error");
  blink_on_a: assert property (
    $rose(wd_alarm_q || dc_alarm_q || mbx_alarm_q) |=> err_led)
    else $error("indicator not lit after alarm");
  code_clear_a: assert property (
    alarm_clr && !in_check |=> al_code_q == `AL_CODE_NONE)
    else $error("status code not cleared");

  // Main scenarios
  safeop_c: cover property (in_check ##1 esm_q == ST_SAFEOP);
  wd_alarm_c: cover property ($rose(wd_alarm_q));
  dc_alarm_c: cover property ($rose(dc_alarm_q) && !wd_alarm_q);
  clear_c: cover property (wd_alarm_q ##1 alarm_clr ##1 !wd_alarm_q);
  mbx_alarm_c: cover property ($rose(mbx_alarm_q));
endmodule // sync_config_checker
`default_nettype wire

// file: test/apb_master_model.sv
// APB master model standing in for the network master
`default_nettype none
module apb_master_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [13:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic err_q;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    err_q = 1'b0;
  end
  // One transfer; request held until pready seen high
  task automatic xfer(input logic w, input logic [11:0] idx,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // apb_master_model
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the configuration checker
`include "sync_check_defines.svh"
`default_nettype none
module tb
  import sync_check_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic wd_al, dc_al, mb_al, err_led, irq;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] esm_state;
  int n_fail, cmp_count;
  sync_config_checker #(.BLINK_HALF_CYCLES(4)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .esm_state(esm_state),
    .watchdog_setup_alarm(wd_al), .clock_sync_setting_alarm(dc_al),
    .mailbox_setup_alarm(mb_al), .err_led(err_led), .irq(irq));
  apb_master_model m (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    m.xfer(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [11:0] i, input logic [31:0] e);
    m.xfer(1'b0, i, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic setup(input logic [1:0] md, input logic [15:0] dv,
    input logic [15:0] tm, input logic [7:0] sm, input logic [7:0] dc,
    input logic [31:0] cy);
    wr(`IDX_WD_DIV, {16'h0000, dv});
    wr(`IDX_WD_TIME, {16'h0000, tm});
    wr(`IDX_SM_CTRL, {24'h00_0000, sm});
    wr(`IDX_DC_ACT, {24'h00_0000, dc});
    wr(`IDX_CYCLE, cy);
    wr(`IDX_ESM_CTRL, {30'h0000_0004, md});
    repeat (2) @(posedge pclk);
  endtask
  // Request SafeOP and judge state, code, alarms and events
  task automatic trial(input logic [1:0] md, input logic [15:0] dv,
    input logic [15:0] tm, input logic [7:0] sm, input logic [7:0] dc,
    input logic [31:0] cy);
    logic [63:0] t;
    logic wd, dce, mbx;
    logic [15:0] code;
    logic [1:0] st;
    t = (64'(dv) + 64'd2) * 64'(`WD_TICK_NS) * 64'(tm);
    wd = sm[`SM_WD_TRIG_BIT] && (t < ((md == SYNC_FREE_RUN) ?
      64'(`FREERUN_MIN_WD_NS) : 64'd2 * 64'(cy)));
    dce = !(dc[2:0] inside {`DC_ACT_OFF, `DC_ACT_SYNC0});
    mbx = sm[3:0] != `SM0_MBX_CODE;
    code = wd ? `AL_CODE_WD : dce ? `AL_CODE_DC :
      mbx ? `AL_CODE_MBX : `AL_CODE_NONE;
    st = (code == 16'h0000) ? 2'b11 : 2'b01;
    setup(md, dv, tm, sm, dc, cy);
    rd(`IDX_ESM_STAT, {code, 9'h000, mbx, dce, wd, 2'b00,
      (code == 16'h0000) ? 2'b11 : 2'b01});
    rd(`IDX_IRQ_STAT, {28'h000_0000, code == 16'h0000, mbx, dce, wd});
    chk({27'h000_0000, esm_state, mb_al, dc_al, wd_al},
      {27'h000_0000, st, mbx, dce, wd});
    wr(`IDX_ESM_CTRL, 32'h0000_0060);
    wr(`IDX_IRQ_CLR, 32'h0000_000f);
  endtask
  task automatic no_check_outside();
    wr(`IDX_WD_TIME, 32'h0000_0001);
    wr(`IDX_DC_ACT, 32'h0000_0001);
    rd(`IDX_ESM_STAT, 32'h0000_0001);
    wr(`IDX_ESM_CTRL, 32'h0000_0020);
    setup(SYNC_DC, 16'h0000, 16'h61a8, 8'h46, 8'h00, 32'd1000000);
    setup(SYNC_DC, 16'h0000, 16'h0001, 8'h46, 8'h01, 32'd1000000);
    rd(`IDX_ESM_STAT, 32'h0000_0003);
    wr(`IDX_ESM_CTRL, 32'h0000_0060);
    wr(`IDX_IRQ_CLR, 32'h0000_000f);
  endtask
  task automatic blink_irq();
    int n;
    wr(`IDX_IRQ_EN, 32'h0000_0001);
    setup(SYNC_FREE_RUN, 16'h0000, 16'h0001, 8'h46, 8'h00, 32'h0);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    n = 0;
    repeat (16) begin
      @(negedge pclk);
      n += (err_led === 1'b1);
    end
    chk(n, 8);
    wr(`IDX_IRQ_EN, 32'h0000_0000);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`IDX_IRQ_EN, 32'h0000_0001);
    wr(`IDX_IRQ_CLR, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`IDX_ESM_CTRL, 32'h0000_0020);
    repeat (2) @(posedge pclk);
    n = 0;
    repeat (8) begin
      @(negedge pclk);
      n += (err_led === 1'b1);
    end
    chk(n, 0);
    rd(`IDX_ESM_STAT, 32'h0000_0001);
  endtask
  initial begin
    n_fail = 0;
    cmp_count = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IDX_ESM_STAT, 32'h0000_0001);
    rd(`IDX_WD_DIV, 32'h0000_0000);
    m.xfer(1'b0, 12'h3ff, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    chk({31'h0, m.err_q}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    trial(SYNC_FREE_RUN, 16'h0000, 16'h61a7, 8'h46, 8'h00, 0);
    trial(SYNC_FREE_RUN, 16'h0000, 16'h61a8, 8'h46, 8'h00, 0);
    trial(SYNC_FREE_RUN, 16'h0001, 16'h411a, 8'h46, 8'h00, 0);
    trial(SYNC_FREE_RUN, 16'h0001, 16'h411b, 8'h46, 8'h00, 0);
    trial(SYNC_DC, 16'h0000, 16'h61a7, 8'h46, 8'h00, 1000000);
    trial(SYNC_DC, 16'h0000, 16'h61a8, 8'h46, 8'h00, 1000000);
    trial(SYNC_SM2, 16'h0000, 16'h61a7, 8'h46, 8'h00, 1000000);
    trial(SYNC_DC, 16'h0000, 16'h0001, 8'h06, 8'h00, 1000000);
    for (int i = 0; i < 8; i++) begin
      trial(SYNC_SM2, 16'h0000, 16'h61a8, 8'h46, 8'(i), 1000);
    end
    trial(SYNC_DC, 16'h0000, 16'h0001, 8'h46, 8'h01, 1000000);
    trial(SYNC_FREE_RUN, 16'h0000, 16'h61a8, 8'h45, 8'h00, 0);
    no_check_outside();
    blink_irq();
    wrap_up();
  end
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
endmodule // tb
`default_nettype wire
